// [branch_target_unit.sv]
// destination address arithmetic for jumps, calls and branches
`timescale 1ns/100ps
`include "decode_consts.svh"
module branch_target_unit
  import decode_pkg::*;
(
  // instruction bytes
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  b1,
  input  wire logic [7:0]  b2,
  input  wire logic [1:0]  length,
  input  wire logic [15:0] op_pc,
  // destinations
  output logic [15:0]      next_pc,
  output logic [15:0]      page_target,
  output logic [15:0]      rel_target,
  output logic [15:0]      far_target,
  output logic [7:0]       offset
);

  // wraps at 64k like the program counter itself
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    return a + b;
  endfunction

  logic [15:0] rel_ext;

  // offset sits in the last byte of the instruction
  assign offset = (length == `LEN_3) ? b2 : b1;
  assign next_pc = add16(op_pc, {14'h0, length});
  // sign extension gives the +127/-128 reach
  assign rel_ext = {{8{offset[7]}}, offset};
  assign rel_target = add16(next_pc, rel_ext);
  // page taken from the following instruction, not this one
  assign page_target = {next_pc[`PAGE_HI:`PAGE_LO],
                        opcode[`OP_PAGE_HI:`OP_PAGE_LO], b1};
  assign far_target = {b1, b2};

endmodule

// [byte_cpu_instruction_decoder.sv]
// opcode decoder: collects instruction bytes and issues a decoded record
`timescale 1ns/100ps
`include "decode_consts.svh"

module byte_cpu_instruction_decoder
  import decode_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // byte stream from the fetch unit
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  fetch_byte,
  input  wire logic [15:0] fetch_pc,
  output logic             fetch_ready,
  // decoded instruction to the datapath
  output logic             dec_valid,
  input  wire logic        dec_ready,
  output out_type          dec_out
);

  state_type   s_r;
  state_type   s_nxt;
  logic        take;
  logic        finish;
  logic [1:0]  pos;
  logic [7:0]  cur_op;
  logic [7:0]  cur_b1;
  logic [7:0]  cur_b2;
  logic [15:0] cur_pc;
  decoded_type cur_info;
  logic [15:0] next_pc;
  logic [15:0] page_target;
  logic [15:0] rel_target;
  logic [15:0] far_target;
  logic [7:0]  offset;

  // one table entry
  function automatic decoded_type mk(input logic [1:0] len, input logic [2:0] cyc,
                                     input op_class_type cls, input mode_type mode,
                                     input cond_type cond);
    decoded_type d;
    d = '0;
    d.len = len;
    d.cycles = cyc;
    d.op_class = cls;
    d.mode = mode;
    d.cond = cond;
    return d;
  endfunction

  // opcodes past the main map that the core still needs
  function automatic decoded_type decode_high(input logic [7:0] op);
    decoded_type d;
    d = mk(`LEN_1, `CYC_1, c_unsup, m_none, k_none);
    case (op)
      `OP_DEC_BRANCH_DIR: d = mk(`LEN_3, `CYC_2, c_branch, m_direct, k_dec_nonzero);
      `OP_XRD_PTR: d = mk(`LEN_1, `CYC_2, c_xram_read, m_ptr, k_none);
      `OP_XRD_R0,
      `OP_XRD_R1: d = mk(`LEN_1, `CYC_2, c_xram_read, m_ind, k_none);
      `OP_XWR_PTR: d = mk(`LEN_1, `CYC_2, c_xram_write, m_ptr, k_none);
      `OP_XWR_R0,
      `OP_XWR_R1: d = mk(`LEN_1, `CYC_2, c_xram_write, m_ind, k_none);
      default: begin
        if (op[7:4] == `HI_DEC_BRANCH && op[3]) begin
          d = mk(`LEN_2, `CYC_2, c_branch, m_reg, k_dec_nonzero);
        end
      end
    endcase
    return d;
  endfunction

  // column 0: short branches and odd singles
  function automatic decoded_type decode_col0(input logic [3:0] hi);
    decoded_type d;
    case (hi)
      4'h0: d = mk(`LEN_1, `CYC_1, c_nop, m_none, k_none);
      4'h1: d = mk(`LEN_3, `CYC_2, c_branch, m_bit, k_bit_set_clear);
      4'h2: d = mk(`LEN_3, `CYC_2, c_branch, m_bit, k_bit_set);
      4'h3: d = mk(`LEN_3, `CYC_2, c_branch, m_bit, k_bit_clear);
      4'h4: d = mk(`LEN_2, `CYC_2, c_branch, m_rel, k_carry_set);
      4'h5: d = mk(`LEN_2, `CYC_2, c_branch, m_rel, k_carry_clear);
      4'h6: d = mk(`LEN_2, `CYC_2, c_branch, m_rel, k_acc_zero);
      4'h7: d = mk(`LEN_2, `CYC_2, c_branch, m_rel, k_acc_nonzero);
      4'h8: d = mk(`LEN_2, `CYC_2, c_jump, m_rel, k_always);
      4'h9: d = mk(`LEN_3, `CYC_2, c_ptr_load, m_imm16, k_none);
      4'hA,
      4'hB: d = mk(`LEN_2, `CYC_2, c_bit, m_bit, k_none);
      4'hC: d = mk(`LEN_2, `CYC_2, c_stack, m_direct, k_none);
      default: d = mk(`LEN_1, `CYC_1, c_unsup, m_none, k_none);
    endcase
    return d;
  endfunction

  // column 2: far transfers, returns, direct logic, bit moves
  function automatic decoded_type decode_col2(input logic [3:0] hi);
    decoded_type d;
    case (hi)
      4'h0: d = mk(`LEN_3, `CYC_2, c_jump, m_far, k_none);
      4'h1: d = mk(`LEN_3, `CYC_2, c_call, m_far, k_none);
      4'h2: d = mk(`LEN_1, `CYC_2, c_ret, m_none, k_none);
      4'h3: d = mk(`LEN_1, `CYC_2, c_iret, m_none, k_none);
      4'h4,
      4'h5,
      4'h6: d = mk(`LEN_2, `CYC_1, c_alu, m_direct, k_none);
      4'h7,
      4'h8,
      4'h9: d = mk(`LEN_2, `CYC_2, c_bit, m_bit, k_none);
      4'hA,
      4'hB,
      4'hC: d = mk(`LEN_2, `CYC_1, c_bit, m_bit, k_none);
      default: d = mk(`LEN_1, `CYC_1, c_unsup, m_none, k_none);
    endcase
    return d;
  endfunction

  // column 3: rotates, indirect program reads, carry ops
  function automatic decoded_type decode_col3(input logic [3:0] hi);
    decoded_type d;
    case (hi)
      4'h0,
      4'h1,
      4'h2,
      4'h3: d = mk(`LEN_1, `CYC_1, c_alu, m_acc, k_none);
      4'h4,
      4'h5,
      4'h6: d = mk(`LEN_3, `CYC_2, c_alu, m_direct, k_none);
      4'h7: d = mk(`LEN_1, `CYC_2, c_jump, m_acc_ptr, k_none);
      4'h8: d = mk(`LEN_1, `CYC_2, c_code_read, m_acc_pc, k_none);
      4'h9: d = mk(`LEN_1, `CYC_2, c_code_read, m_acc_ptr, k_none);
      4'hA: d = mk(`LEN_1, `CYC_2, c_alu, m_ptr, k_none);
      4'hB,
      4'hC: d = mk(`LEN_1, `CYC_1, c_bit, m_none, k_none);
      default: d = mk(`LEN_1, `CYC_1, c_unsup, m_none, k_none);
    endcase
    return d;
  endfunction

  // column 4: accumulator and immediate forms
  function automatic decoded_type decode_col4(input logic [3:0] hi);
    decoded_type d;
    case (hi)
      4'h0,
      4'h1,
      4'hC: d = mk(`LEN_1, `CYC_1, c_alu, m_acc, k_none);
      4'h2,
      4'h3,
      4'h4,
      4'h5,
      4'h6,
      4'h9: d = mk(`LEN_2, `CYC_1, c_alu, m_imm8, k_none);
      4'h7: d = mk(`LEN_2, `CYC_1, c_move, m_imm8, k_none);
      4'h8,
      4'hA: d = mk(`LEN_1, `CYC_4, c_alu, m_acc, k_none);
      4'hB: d = mk(`LEN_3, `CYC_2, c_branch, m_imm8, k_unequal);
      default: d = mk(`LEN_1, `CYC_1, c_unsup, m_none, k_none);
    endcase
    return d;
  endfunction

  // column 5: direct forms
  function automatic decoded_type decode_col5(input logic [3:0] hi);
    decoded_type d;
    case (hi)
      4'h0,
      4'h1,
      4'h2,
      4'h3,
      4'h4,
      4'h5,
      4'h6,
      4'h9: d = mk(`LEN_2, `CYC_1, c_alu, m_direct, k_none);
      4'h7,
      4'h8: d = mk(`LEN_3, `CYC_2, c_move, m_direct, k_none);
      4'hA: d = mk(`LEN_1, `CYC_1, c_reserved, m_none, k_none);
      4'hB: d = mk(`LEN_3, `CYC_2, c_branch, m_direct, k_unequal);
      4'hC: d = mk(`LEN_2, `CYC_1, c_move, m_direct, k_none);
      default: d = mk(`LEN_1, `CYC_1, c_unsup, m_none, k_none);
    endcase
    return d;
  endfunction

  // columns 6 to F: indirect and register forms share one layout
  function automatic decoded_type decode_rm(input logic [3:0] hi, input mode_type rm);
    decoded_type d;
    case (hi)
      4'h0,
      4'h1,
      4'h2,
      4'h3,
      4'h4,
      4'h5,
      4'h6,
      4'h9: d = mk(`LEN_1, `CYC_1, c_alu, rm, k_none);
      4'h7: d = mk(`LEN_2, `CYC_1, c_move, rm, k_none);
      4'h8,
      4'hA: d = mk(`LEN_2, `CYC_2, c_move, rm, k_none);
      4'hB: d = mk(`LEN_3, `CYC_2, c_branch, rm, k_unequal);
      4'hC: d = mk(`LEN_1, `CYC_1, c_move, rm, k_none);
      default: d = mk(`LEN_1, `CYC_1, c_unsup, m_none, k_none);
    endcase
    return d;
  endfunction

  // whole-opcode decode; selectors fill in last for every form
  function automatic decoded_type decode(input logic [7:0] op);
    decoded_type d;
    logic [3:0]  hi;
    logic [3:0]  lo;
    hi = op[7:4];
    lo = op[3:0];
    if (hi > `HI_LAST) begin
      d = decode_high(op);
    end else begin
      case (lo)
        4'h0: d = decode_col0(hi);
        4'h1: d = mk(`LEN_2, `CYC_2, op[`CALL_BIT] ? c_call : c_jump,
                     m_page, k_none);
        4'h2: d = decode_col2(hi);
        4'h3: d = decode_col3(hi);
        4'h4: d = decode_col4(hi);
        4'h5: d = decode_col5(hi);
        4'h6,
        4'h7: d = decode_rm(hi, m_ind);
        default: d = decode_rm(hi, m_reg);
      endcase
    end
    d.reg_idx = op[`REG_HI:`REG_LO];
    d.ind_sel = op[`IND_BIT];
    return d;
  endfunction

  // byte index of the incoming byte within the instruction
  function automatic logic [1:0] byte_pos(input fsm_type st);
    case (st)
      st_opcode:   return `LEN_1;
      st_operand1: return `LEN_2;
      default:     return `LEN_3;
    endcase
  endfunction

  branch_target_unit u_target (
    .opcode      (cur_op),
    .b1          (cur_b1),
    .b2          (cur_b2),
    .length      (cur_info.len),
    .op_pc       (cur_pc),
    .next_pc     (next_pc),
    .page_target (page_target),
    .rel_target  (rel_target),
    .far_target  (far_target),
    .offset      (offset)
  );

  // bytes not yet stored come from the fetch port; absent ones read zero, except cur_b1 in st_issue, which reads s_r.b1, stale after a one-byte instruction
  assign cur_op = (s_r.state == st_opcode) ? fetch_byte : s_r.op;
  assign cur_pc = (s_r.state == st_opcode) ? fetch_pc : s_r.pc;
  assign cur_b1 = (s_r.state == st_operand1) ? fetch_byte :
                  (s_r.state == st_opcode) ? 8'h00 : s_r.b1;
  assign cur_b2 = (s_r.state == st_operand2) ? fetch_byte : 8'h00;
  assign cur_info = decode(cur_op);

  // handshakes; enable low must not let a byte or record slip
  assign fetch_ready = clk_en && (s_r.state != st_issue);
  assign dec_valid = clk_en && (s_r.state == st_issue);
  assign take = fetch_valid && fetch_ready;
  assign pos = byte_pos(s_r.state);
  assign finish = take && (pos == cur_info.len);
  assign dec_out = s_r.out;

  // next-state and record assembly
  always_comb begin
    s_nxt = s_r;
    case (s_r.state)
      st_opcode: begin
        if (take) begin
          s_nxt.op = fetch_byte;
          s_nxt.pc = fetch_pc;
          s_nxt.state = st_operand1;
        end
      end
      st_operand1: begin
        if (take) begin
          s_nxt.b1 = fetch_byte;
          s_nxt.state = st_operand2;
        end
      end
      st_operand2: begin
        if (take) begin
          s_nxt.state = st_issue;
        end
      end
      st_issue: begin
        if (dec_ready) begin
          s_nxt.state = st_opcode;
        end
      end
      default: s_nxt.state = st_opcode;
    endcase
    if (finish) begin
      s_nxt.state = st_issue;
      s_nxt.out.info = cur_info;
      s_nxt.out.opcode = cur_op;
      s_nxt.out.b1 = cur_b1;
      // unused trailing bytes read as zero
      s_nxt.out.b2 = (cur_info.len == `LEN_3) ? cur_b2 : 8'h00;
      if (cur_info.len == `LEN_1) begin
        s_nxt.out.b1 = 8'h00;
      end
      s_nxt.out.op_pc = cur_pc;
      s_nxt.out.next_pc = next_pc;
      s_nxt.out.direct_addr = cur_b1;
      s_nxt.out.direct_is_sfr = cur_b1[`SPACE_BIT];
      s_nxt.out.bit_addr = cur_b1;
      s_nxt.out.bit_is_sfr = cur_b1[`SPACE_BIT];
      // immediate after a direct operand sits in the third byte
      s_nxt.out.imm8 = (cur_info.len == `LEN_3 && cur_info.cond != k_unequal)
                       ? cur_b2 : cur_b1;
      s_nxt.out.imm16 = far_target;
      s_nxt.out.rel_offset = offset;
      // accumulator-relative jumps resolve in the datapath
      case (cur_info.mode)
        m_page: s_nxt.out.target = page_target;
        m_far: s_nxt.out.target = far_target;
        default: s_nxt.out.target = (cur_info.cond != k_none) ? rel_target : next_pc;
      endcase
    end
  end

  // single state register, frozen while the enable is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

endmodule

// [byte_cpu_instruction_decoder_assertions.sv]
// port checks for the opcode decoder
`timescale 1ns/100ps
module decoder_checker
  import decode_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  // fetch side
  input wire logic        fetch_valid,
  input wire logic [7:0]  fetch_byte,
  input wire logic [15:0] fetch_pc,
  input wire logic        fetch_ready,
  // decoded side
  input wire logic        dec_valid,
  input wire logic        dec_ready,
  input out_type          dec_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  out_type d;

  // short alias keeps the properties readable
  assign d = dec_out;

  property p_reg; dec_valid |-> d.info.reg_idx == d.opcode[2:0] && d.info.ind_sel == d.opcode[0];
  endproperty
  a_reg: assert property (p_reg) else $error("register select wrong");
  property p_dir;
    dec_valid |-> d.direct_addr == d.b1 && d.direct_is_sfr == d.b1[7] && d.bit_is_sfr == d.b1[7];
  endproperty
  a_dir: assert property (p_dir) else $error("address byte wrong");
  property p_imm16; dec_valid && d.info.len == 2'h3 |-> d.imm16 == {d.b1, d.b2}; endproperty
  a_imm16: assert property (p_imm16) else $error("wide constant wrong");
  property p_far; dec_valid && d.info.mode == m_far |-> d.target == {d.b1, d.b2}; endproperty
  a_far: assert property (p_far) else $error("far target wrong");
  property p_next; dec_valid |-> d.next_pc == d.op_pc + 16'(d.info.len); endproperty
  a_next: assert property (p_next) else $error("next address wrong");
  property p_page;
    dec_valid && d.info.mode == m_page |-> d.target == {d.next_pc[15:11], d.opcode[7:5], d.b1};
  endproperty
  a_page: assert property (p_page) else $error("page target wrong");
  property p_rel;
    dec_valid && d.info.cond != k_none
      |-> d.target == d.next_pc + {{8{d.rel_offset[7]}}, d.rel_offset};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_pgop;
    dec_valid && d.opcode[3:0] == 4'h1 && d.opcode < 8'hD0 |-> d.info.len == 2'h2;
  endproperty
  a_pgop: assert property (p_pgop) else $error("page opcode length wrong");
  property p_cmp;
    dec_valid && d.opcode >= 8'hB4 && d.opcode <= 8'hBF
      |-> d.info.len == 2'h3 && d.info.cycles == 3'h2;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare branch shape wrong");
  property p_resv; dec_valid && d.opcode == 8'hA5 |-> d.info.op_class == c_reserved; endproperty
  a_resv: assert property (p_resv) else $error("reserved opcode class wrong");
  // a refused record must not move; clk_en low only freezes it
  property p_hold; dec_valid && !dec_ready && clk_en |=> $stable(d) && (dec_valid || !clk_en);
  endproperty
  a_hold: assert property (p_hold) else $error("pending record changed");
  property p_ans; $rose(dec_valid) && $past(clk_en) |-> $past(fetch_valid && fetch_ready);
  endproperty
  a_ans: assert property (p_ans) else $error("record without a taken byte");

  c_three: cover property (dec_valid && d.info.len == 2'h3);
  c_stall: cover property (dec_valid && !dec_ready ##1 dec_valid);
  c_page: cover property (dec_valid && d.info.mode == m_page);
endmodule

bind byte_cpu_instruction_decoder decoder_checker i_decoder_checker (.clk(clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_pc(fetch_pc),
  .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_out(dec_out));

// [byte_cpu_instruction_decoder_tb_top.sv]
// self-checking bench for the opcode decoder
`timescale 1ns/100ps
module byte_cpu_instruction_decoder_tb_top
  import decode_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        stall = 1'b0;
  logic        fetch_valid, fetch_ready, dec_valid, dec_ready;
  logic [7:0]  fetch_byte;
  logic [15:0] fetch_pc;
  logic [15:0] at_pc = 16'h0200;
  out_type     dec_out, rec;
  int          fail_count = 0;
  int          comparisons = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  byte_cpu_instruction_decoder i_byte_cpu_instruction_decoder (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_pc(fetch_pc),
    .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_out(dec_out));
  fetch_model i_fetch_model (.clk(clk), .stall(stall), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_pc(fetch_pc),
    .dec_valid(dec_valid), .dec_ready(dec_ready));

  // verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // instruction into model memory; model offers exactly n bytes
  task automatic load(input logic [7:0] op, b1, b2, input logic [1:0] n);
    @(negedge clk);
    i_fetch_model.mem[at_pc] = op;
    i_fetch_model.mem[at_pc + 16'h1] = b1;
    i_fetch_model.mem[at_pc + 16'h2] = b2;
    i_fetch_model.pc_r = at_pc;
    i_fetch_model.left_r = n;
  endtask

  // bounded wait; without stall the record is taken at the closing edge
  task automatic wait_rec;
    int k;
    k = 0;
    while (dec_valid !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("record", 16'h1, 16'(dec_valid));
    rec = dec_out;
    @(posedge clk);
  endtask

  // cycles of zero are left unchecked
  task automatic row(input logic [7:0] op, b1, b2, input logic [1:0] ln, input logic [2:0] cy);
    load(op, b1, b2, ln);
    wait_rec();
    chk("opcode", 16'(op), 16'(rec.opcode));
    chk("len", 16'(ln), 16'(rec.info.len));
    if (cy != 3'h0) chk("cycles", 16'(cy), 16'(rec.info.cycles));
  endtask

  task automatic t_regs;
    logic [7:0] ops [6] = '{8'h06, 8'h07, 8'h26, 8'h27, 8'hE2, 8'hE3};
    chk("idle", 16'h1, 16'(!dec_valid && fetch_ready && dec_out == '0));
    for (int i = 0; i < 8; i++) begin
      row(8'h08 + 8'(i), 8'h00, 8'h00, 2'h1, 3'h0);
      chk("reg_idx", 16'(i), 16'(rec.info.reg_idx));
    end
    for (int i = 0; i < 6; i++) begin
      row(ops[i], 8'h00, 8'h00, 2'h1, (i > 3) ? 3'h2 : 3'h0);
      chk("ind_sel", 16'(ops[i][0]), 16'(rec.info.ind_sel));
    end
    chk("class", 16'(c_xram_read), 16'(rec.info.op_class));
    row(8'hE0, 8'h00, 8'h00, 2'h1, 3'h2);
    chk("class", 16'(c_xram_read), 16'(rec.info.op_class));
  endtask

  task automatic t_addr;
    row(8'h05, 8'h7F, 8'h00, 2'h2, 3'h0);
    chk("direct", 16'h007F, {7'h0, rec.direct_is_sfr, rec.direct_addr});
    row(8'h05, 8'h80, 8'h00, 2'h2, 3'h0);
    chk("direct", 16'h0180, {7'h0, rec.direct_is_sfr, rec.direct_addr});
    row(8'hC2, 8'h80, 8'h00, 2'h2, 3'h0);
    chk("bit", 16'h0180, {7'h0, rec.bit_is_sfr, rec.bit_addr});
    row(8'h72, 8'h7F, 8'h00, 2'h2, 3'h0);
    chk("bit", 16'h007F, {7'h0, rec.bit_is_sfr, rec.bit_addr});
    row(8'h90, 8'h12, 8'h34, 2'h3, 3'h2);
    chk("imm16", 16'h1234, rec.imm16);
    chk("class", 16'(c_ptr_load), 16'(rec.info.op_class));
    row(8'h75, 8'h30, 8'h99, 2'h3, 3'h2);
    chk("imm8", 16'h0099, 16'(rec.imm8));
    row(8'hC0, 8'h81, 8'h00, 2'h2, 3'h0);
    chk("direct", 16'h0181, {7'h0, rec.direct_is_sfr, rec.direct_addr});
    chk("class", 16'(c_stack), 16'(rec.info.op_class));
  endtask

  // far targets, then every page opcode from just below a page edge
  task automatic t_jump;
    logic [7:0] op;
    at_pc = 16'hFFF0;
    row(8'h02, 8'hAB, 8'hCD, 2'h3, 3'h2);
    chk("target", 16'hABCD, rec.target);
    chk("op_pc", 16'hFFF0, rec.op_pc);
    chk("next_pc", 16'hFFF3, rec.next_pc);
    row(8'h12, 8'h00, 8'h07, 2'h3, 3'h2);
    chk("target", 16'h0007, rec.target);
    at_pc = 16'h07FE;
    for (int i = 0; i < 13; i++) begin
      op = {3'(i / 2), i[0] ? 5'h11 : 5'h01};
      row(op, 8'h3C, 8'h00, 2'h2, 3'h2);
      chk("target", {5'h01, op[7:5], 8'h3C}, rec.target);
      chk("class", 16'(op[4] ? c_call : c_jump), 16'(rec.info.op_class));
    end
  endtask

  // offsets at both ends of the signed range
  task automatic t_rel;
    logic [7:0] ops [9] = '{8'h80, 8'h40, 8'h50, 8'h60, 8'h70, 8'h10, 8'hB4, 8'hD8, 8'hD5};
    cond_type cs [9] = '{k_always, k_carry_set, k_carry_clear, k_acc_zero, k_acc_nonzero,
      k_bit_set_clear, k_unequal, k_dec_nonzero, k_dec_nonzero};
    logic [1:0] ln;
    logic [7:0] off;
    at_pc = 16'h1000;
    for (int i = 0; i < 9; i++) begin
      ln = (i > 4 && i != 7) ? 2'h3 : 2'h2;
      off = i[0] ? 8'h7F : 8'h80;
      row(ops[i], (ln == 2'h3) ? 8'h20 : off, off, ln, 3'h2);
      chk("cond", 16'(cs[i]), 16'(rec.info.cond));
      chk("target", 16'h1000 + 16'(ln) + {{8{off[7]}}, off}, rec.target);
      chk("rel_offset", 16'(off), 16'(rec.rel_offset));
    end
    for (int i = 4; i < 16; i++) begin
      row({4'hB, 4'(i)}, 8'h20, 8'h05, 2'h3, 3'h2);
      chk("cond", 16'(k_unequal), 16'(rec.info.cond));
    end
  endtask

  task automatic t_misc;
    row(8'h93, 8'h00, 8'h00, 2'h1, 3'h2);
    chk("mode", 16'(m_acc_ptr), 16'(rec.info.mode));
    chk("direct", 16'h0000, {rec.direct_addr, rec.b1});
    chk("imm16", 16'h0000, rec.imm16);
    row(8'h83, 8'h00, 8'h00, 2'h1, 3'h2);
    chk("class", 16'(c_code_read), 16'(rec.info.op_class));
    row(8'h73, 8'h00, 8'h00, 2'h1, 3'h2);
    chk("class", 16'(c_jump), 16'(rec.info.op_class));
    row(8'hA5, 8'h00, 8'h00, 2'h1, 3'h0);
    chk("class", 16'(c_reserved), 16'(rec.info.op_class));
  endtask

  // refused record must stand; clock enable low freezes the fetch side
  task automatic t_flow;
    @(negedge clk);
    stall = 1'b1;
    load(8'h74, 8'h11, 8'h00, 2'h2);
    wait_rec();
    chk("imm8", 16'h0011, 16'(rec.imm8));
    repeat (4) begin
      @(negedge clk);
      chk("held", 16'h1, 16'(dec_valid && !fetch_ready && dec_out == rec));
    end
    stall = 1'b0;
    repeat (2) @(negedge clk);
    chk("taken", 16'h1, 16'(!dec_valid && fetch_ready));
    @(posedge clk);
    #1 clk_en = 1'b0;
    load(8'h00, 8'h00, 8'h00, 2'h1);
    repeat (3) @(negedge clk);
    chk("frozen", 16'h1, 16'(!fetch_ready && !dec_valid && i_fetch_model.left_r == 2'h1));
    @(posedge clk);
    #1 clk_en = 1'b1;
    wait_rec();
    chk("len", 16'h1, 16'(rec.info.len));
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    @(negedge clk);
    t_regs();
    t_addr();
    t_jump();
    t_rel();
    t_misc();
    t_flow();
    complete_run();
  end

  // hang guard, several times the expected run
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule

// [decode_consts.svh]
// named constants for the opcode decoder
`ifndef DECODE_CONSTS_SVH
`define DECODE_CONSTS_SVH

// instruction lengths in bytes
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

// machine-cycle counts
`define CYC_1 3'h1
`define CYC_2 3'h2
`define CYC_4 3'h4

// opcode map boundaries and odd opcodes
`define HI_LAST           4'hC
`define HI_DEC_BRANCH     4'hD
`define OP_DEC_BRANCH_DIR 8'hD5
`define OP_XRD_PTR        8'hE0
`define OP_XRD_R0         8'hE2
`define OP_XRD_R1         8'hE3
`define OP_XWR_PTR        8'hF0
`define OP_XWR_R0         8'hF2
`define OP_XWR_R1         8'hF3

// field positions
`define SPACE_BIT   7
`define PAGE_HI     15
`define PAGE_LO     11
`define OP_PAGE_HI  7
`define OP_PAGE_LO  5
`define REG_HI      2
`define REG_LO      0
`define IND_BIT     0
`define CALL_BIT    4

`endif

// [decode_pkg.sv]
// types shared by the opcode decoder files
package decode_pkg;

  typedef enum logic [3:0] {
    c_nop        = 4'h0,
    c_alu        = 4'h1,
    c_move       = 4'h2,
    c_bit        = 4'h3,
    c_jump       = 4'h4,
    c_call       = 4'h5,
    c_ret        = 4'h6,
    c_iret       = 4'h7,
    c_branch     = 4'h8,
    c_code_read  = 4'h9,
    c_xram_read  = 4'hA,
    c_xram_write = 4'hB,
    c_stack      = 4'hC,
    c_ptr_load   = 4'hD,
    c_reserved   = 4'hE,
    c_unsup      = 4'hF
  } op_class_type;

  typedef enum logic [3:0] {
    m_none = 4'h0, m_acc = 4'h1, m_reg = 4'h2, m_direct = 4'h3,
    m_ind = 4'h4, m_imm8 = 4'h5, m_imm16 = 4'h6, m_bit = 4'h7,
    m_page = 4'h8, m_far = 4'h9, m_rel = 4'hA, m_acc_ptr = 4'hB,
    m_acc_pc = 4'hC, m_ptr = 4'hD
  } mode_type;

  typedef enum logic [3:0] {
    k_none = 4'h0, k_always = 4'h1, k_bit_set = 4'h2, k_bit_clear = 4'h3,
    k_bit_set_clear = 4'h4, k_carry_set = 4'h5, k_carry_clear = 4'h6,
    k_acc_zero = 4'h7, k_acc_nonzero = 4'h8, k_unequal = 4'h9,
    k_dec_nonzero = 4'hA
  } cond_type;

  typedef enum logic [1:0] {
    st_opcode   = 2'b00,
    st_operand1 = 2'b01,
    st_operand2 = 2'b10,
    st_issue    = 2'b11
  } fsm_type;

  typedef struct packed {
    logic [1:0]   len;
    logic [2:0]   cycles;
    op_class_type op_class;
    mode_type     mode;
    cond_type     cond;
    logic [2:0]   reg_idx;
    logic         ind_sel;
  } decoded_type;

  typedef struct packed {
    decoded_type info;
    logic [7:0]  opcode;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [15:0] op_pc;
    logic [15:0] next_pc;
    logic [15:0] target;
    logic [7:0]  direct_addr;
    logic        direct_is_sfr;
    logic [7:0]  imm8;
    logic [15:0] imm16;
    logic [7:0]  bit_addr;
    logic        bit_is_sfr;
    logic [7:0]  rel_offset;
  } out_type;

  typedef struct packed {
    fsm_type     state;
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [15:0] pc;
    out_type     out;
  } state_type;

endpackage

// [fetch_model.sv]
// behavioural fetch unit and datapath sink around the decoder
`timescale 1ns/100ps
module fetch_model
(
  // clock and bench control
  input  wire logic        clk,
  input  wire logic        stall,
  // byte stream to the decoder
  input  wire logic        fetch_ready,
  output logic             fetch_valid,
  output logic [7:0]       fetch_byte,
  output logic [15:0]      fetch_pc,
  // record sink
  input  wire logic        dec_valid,
  output logic             dec_ready
);
  logic [7:0]  mem [0:65535];
  logic [15:0] pc_r = 16'h0000;
  logic [1:0]  left_r = 2'h0;
  logic [7:0]  last_r = 8'h00;
  logic        stall_s;

  // idle at power-up
  initial begin
    fetch_valid = 1'b0;
    fetch_byte = 8'hFF;
    fetch_pc = 16'hFFFF;
    dec_ready = 1'b0;
  end

  // bytes held until taken; idle lines show inverted data so stale values never match
  always @(posedge clk) begin
    stall_s = stall;
    if (fetch_valid && fetch_ready) begin
      pc_r = pc_r + 16'h1;
      left_r = left_r - 2'h1;
      last_r = fetch_byte;
    end
    #1;
    fetch_valid = (left_r != 2'h0);
    fetch_byte = fetch_valid ? mem[pc_r] : ~last_r;
    fetch_pc = fetch_valid ? pc_r : ~pc_r;
    dec_ready = dec_valid & ~stall_s;
  end
endmodule
